// ==== hdl/usi_cfg.svh ====
// Register offsets, field positions and reset values for the UART secondary interrupt sources
`ifndef USI_CFG_SVH
`define USI_CFG_SVH
`define USI_OFS_SPC_EN 8'h05
`define USI_OFS_SPC_FLAGS 8'h06
`define USI_OFS_STS_EN 8'h07
`define USI_OFS_STS_FLAGS 8'h08
`define USI_SPC_MASK 8'h3F
`define USI_STS_MASK 8'h2F
`define USI_STS_SETTLED_BIT 5
`define USI_RST_REG 8'h00
`define USI_PINS_PER_UART 4
`endif

// ==== hdl/usi_pkg.sv ====
// Types shared by the UART secondary interrupt sources block
package usi_pkg;
	typedef struct packed {
		logic addr_char;
		logic line_break;
		logic stop2_match;
		logic stop1_match;
		logic resume2_match;
		logic resume1_match;
	} usi_spc_evt_t;
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} usi_reg_req_t;
	typedef enum logic [1:0] {
		USI_CLK_OFF = 2'b00,
		USI_CLK_SETTLING = 2'b01,
		USI_CLK_READY = 2'b10
	} usi_clk_state_t;
endpackage

// ==== hdl/usi_irq_sources.sv ====
// Per-UART special-character and status interrupt flags, masks and summary bits
`timescale 1ns/1ps
`include "usi_cfg.svh"

// Operation
// - Special-character enable bits 0-5 pass their flags into summary bit 1; cleared enables block them.
// - The address-character flag sets on an address character while 9-bit multidrop mode is on.
// - The line-break flag sets when the receiver reports a break longer than one character.
// - With detection on, stop2, stop1, resume2 and resume1 matches set flag bits 3, 2, 1 and 0.
// - Reading the special-character flag register clears all of its flags except those set in the same cycle.
// - Enable bit 5 of the status enable register routes clock-settled into summary bit 2.
// - Status enable bits 3-0 route the matching pin-change flags into summary bit 2.
// - Pin-change flag n of UART u watches pin 4u+n.
// - Clock-settled status sets once source, divider and PLL have all settled.
// - Clock-settled status never sets when an external clock is the source.
// - Clock-settled clears only when the clock is disabled, never on a read.
// - A pin-change flag sets on every level change of its pin unless its enable is low.
// - Pin-change flags clear when the status flag register is read.
// - Summary bit 2 sets on any enabled status flag and clears on a main status read.
// - Summary bit 1 sets on enabled special-character events and clears on a main status read.
module usi_irq_sources #(
	parameter int UART_INDEX = 0,
	parameter int NUM_PINS = 16
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic clk_en,
	input wire usi_pkg::usi_reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	input wire logic main_status_rd,
	input wire usi_pkg::usi_spc_evt_t spc_evt,
	input wire logic multidrop_on,
	input wire logic special_detect_on,
	input wire logic clk_enabled,
	input wire logic clk_from_xtal,
	input wire logic pll_locked,
	input wire logic div_settled,
	input wire logic [NUM_PINS-1:0] pin_in,
	output logic special_summary,
	output logic status_summary
);
	// ****************************************
	// Register access decode
	// ****************************************
	wire rd_spc_en = reg_req.rd && reg_req.addr == `USI_OFS_SPC_EN;
	wire rd_spc_fl = reg_req.rd && reg_req.addr == `USI_OFS_SPC_FLAGS;
	wire rd_sts_en = reg_req.rd && reg_req.addr == `USI_OFS_STS_EN;
	wire rd_sts_fl = reg_req.rd && reg_req.addr == `USI_OFS_STS_FLAGS;
	wire wr_spc_en = reg_req.wr && reg_req.addr == `USI_OFS_SPC_EN;
	wire wr_sts_en = reg_req.wr && reg_req.addr == `USI_OFS_STS_EN;

	logic [7:0] special_char_irq_enable;
	logic [7:0] special_char_irq_flags;
	logic [7:0] status_irq_enable;
	logic [3:0] pin_change_flag;
	logic clk_settled;
	usi_pkg::usi_clk_state_t clk_state;
	usi_pkg::usi_clk_state_t next_clk_state;

	// ****************************************
	// Pin synchronisers and change detect
	// ****************************************
	localparam int PIN_BASE = UART_INDEX * `USI_PINS_PER_UART;
	logic [3:0] pin_s1;
	logic [3:0] pin_s2;
	logic [3:0] pin_s3;
	logic [3:0] pin_change;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_pin
			always_ff @(posedge clk_sys) begin
				if (!resetn) begin
					pin_s1[gi] <= 1'b0;
					pin_s2[gi] <= 1'b0;
					pin_s3[gi] <= 1'b0;
				end else if (clk_en) begin
					pin_s1[gi] <= pin_in[PIN_BASE + gi];
					pin_s2[gi] <= pin_s1[gi];
					pin_s3[gi] <= pin_s2[gi];
				end
			end
			// Change counts once the second and third stages disagree with history
			assign pin_change[gi] = (pin_s2[gi] != pin_s3[gi]) && status_irq_enable[gi];
		end
	endgenerate

	// ****************************************
	// Special-character flags
	// ****************************************
	wire [5:0] spc_set = {spc_evt.addr_char && multidrop_on,
		spc_evt.line_break,
		spc_evt.stop2_match && special_detect_on,
		spc_evt.stop1_match && special_detect_on,
		spc_evt.resume2_match && special_detect_on,
		spc_evt.resume1_match && special_detect_on};
	// Set wins over the clearing read
	wire [5:0] next_spc_flags = spc_set | (rd_spc_fl ? 6'h00 : special_char_irq_flags[5:0]);
	wire [3:0] next_pin_flags = pin_change | (rd_sts_fl ? 4'h0 : pin_change_flag);

	// ****************************************
	// Clock-settled tracking
	// ****************************************
	wire all_settled = clk_from_xtal && pll_locked && div_settled;
	always_comb begin
		next_clk_state = clk_state;
		case (clk_state)
			usi_pkg::USI_CLK_OFF: begin
				if (clk_enabled && clk_from_xtal) begin
					next_clk_state = usi_pkg::USI_CLK_SETTLING;
				end
			end
			usi_pkg::USI_CLK_SETTLING: begin
				if (!clk_enabled || !clk_from_xtal) begin
					next_clk_state = usi_pkg::USI_CLK_OFF;
				end else if (all_settled) begin
					next_clk_state = usi_pkg::USI_CLK_READY;
				end
			end
			usi_pkg::USI_CLK_READY: begin
				if (!clk_enabled) begin
					next_clk_state = usi_pkg::USI_CLK_OFF;
				end
			end
			default: next_clk_state = usi_pkg::USI_CLK_OFF;
		endcase
	end
	wire next_clk_settled = (next_clk_state == usi_pkg::USI_CLK_READY);

	// ****************************************
	// Summary bits
	// ****************************************
	wire spc_hit = |(next_spc_flags & special_char_irq_enable[5:0] & spc_set);
	wire sts_hit = |(pin_change & status_irq_enable[3:0])
		|| (next_clk_settled && !clk_settled
		&& status_irq_enable[`USI_STS_SETTLED_BIT]);
	wire next_special_summary = spc_hit || (special_summary && !main_status_rd);
	wire next_status_summary = sts_hit || (status_summary && !main_status_rd);

	// ****************************************
	// Read data
	// ****************************************
	wire [7:0] sts_view = {2'b00, clk_settled, 1'b0, pin_change_flag};
	wire [7:0] next_rdata = rd_spc_en ? special_char_irq_enable :
		rd_spc_fl ? special_char_irq_flags :
		rd_sts_en ? status_irq_enable :
		rd_sts_fl ? sts_view : `USI_RST_REG;

	// ****************************************
	// State registers
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			special_char_irq_enable <= `USI_RST_REG;
			special_char_irq_flags <= `USI_RST_REG;
			status_irq_enable <= `USI_RST_REG;
			pin_change_flag <= 4'h0;
			clk_state <= usi_pkg::USI_CLK_OFF;
			clk_settled <= 1'b0;
			special_summary <= 1'b0;
			status_summary <= 1'b0;
			reg_rdata <= `USI_RST_REG;
		end else if (clk_en) begin
			if (wr_spc_en) begin
				special_char_irq_enable <= reg_req.wdata & `USI_SPC_MASK;
			end
			if (wr_sts_en) begin
				status_irq_enable <= reg_req.wdata & `USI_STS_MASK;
			end
			special_char_irq_flags <= {2'b00, next_spc_flags};
			pin_change_flag <= next_pin_flags;
			clk_state <= next_clk_state;
			clk_settled <= next_clk_settled;
			special_summary <= next_special_summary;
			status_summary <= next_status_summary;
			reg_rdata <= next_rdata;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	spc_block_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && !special_summary && (spc_set & special_char_irq_enable[5:0]) == 6'h00
		|=> !special_summary)
		else $error("special summary rose with no enabled event");
	spc_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && rd_spc_fl && spc_set == 6'h00 |=> special_char_irq_flags == 8'h00)
		else $error("special flags not cleared by read");
	event_kept_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && rd_spc_fl && spc_evt.line_break |=> special_char_irq_flags[4])
		else $error("break event lost during clearing read");
	xtal_only_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && !clk_from_xtal && !clk_settled |=> !clk_settled)
		else $error("clock settled without crystal source");
	settle_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && clk_settled && clk_enabled |=> clk_settled)
		else $error("clock settled dropped while clock enabled");
	pin_set_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && pin_s2[0] != pin_s3[0] && status_irq_enable[0] |=> pin_change_flag[0])
		else $error("pin change flag missed");
	pin_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && rd_sts_fl && pin_change == 4'h0 |=> pin_change_flag == 4'h0)
		else $error("pin flags not cleared by read");
	sts_summary_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && main_status_rd && !sts_hit |=> !status_summary)
		else $error("status summary not cleared by main read");
	spc_summary_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && main_status_rd && !spc_hit |=> !special_summary)
		else $error("special summary not cleared by main read");
	reserved_zero_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		special_char_irq_enable[7:6] == 2'b00 && status_irq_enable[7:6] == 2'b00
		&& status_irq_enable[4] == 1'b0)
		else $error("reserved enable bit set");

	// ****************************************
	// Register view and flag checks
	// ****************************************
	rdata_idle_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && !reg_req.rd |=> reg_rdata == 8'h00)
		else $error("read data not zero without a read");

	spc_en_view_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && rd_spc_en |=> reg_rdata == $past(special_char_irq_enable))
		else $error("special enable read back wrong");

	sts_en_view_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && rd_sts_en |=> reg_rdata == $past(status_irq_enable))
		else $error("status enable read back wrong");

	settle_view_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && rd_sts_fl |=> reg_rdata[5] == $past(clk_settled))
		else $error("clock settled read back wrong");

	sts_rsvd_view_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && rd_sts_fl |=> reg_rdata[7:6] == 2'b00 && reg_rdata[4] == 1'b0)
		else $error("reserved status bit read nonzero");

	spc_rsvd_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		special_char_irq_flags[7:6] == 2'b00)
		else $error("reserved special flag bit set");

	addr_set_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && spc_evt.addr_char && multidrop_on |=> special_char_irq_flags[5])
		else $error("address character flag missed");

	addr_block_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && !special_char_irq_flags[5] && !(spc_evt.addr_char && multidrop_on)
		|=> !special_char_irq_flags[5])
		else $error("address character flag set without cause");

	brk_set_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && spc_evt.line_break |=> special_char_irq_flags[4])
		else $error("line break flag missed");

	stop2_set_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && spc_evt.stop2_match && special_detect_on |=> special_char_irq_flags[3])
		else $error("stop2 match flag missed");

	stop1_set_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && spc_evt.stop1_match && special_detect_on |=> special_char_irq_flags[2])
		else $error("stop1 match flag missed");

	resume2_set_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && spc_evt.resume2_match && special_detect_on |=> special_char_irq_flags[1])
		else $error("resume2 match flag missed");

	resume1_set_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && spc_evt.resume1_match && special_detect_on |=> special_char_irq_flags[0])
		else $error("resume1 match flag missed");

	detect_off_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && !special_detect_on && special_char_irq_flags[3:0] == 4'h0
		|=> special_char_irq_flags[3:0] == 4'h0)
		else $error("match flag set with detection off");

	spc_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && !rd_spc_fl
		|=> (special_char_irq_flags & $past(special_char_irq_flags))
		== $past(special_char_irq_flags))
		else $error("special flag dropped without a read");

	pin_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && !rd_sts_fl
		|=> (pin_change_flag & $past(pin_change_flag)) == $past(pin_change_flag))
		else $error("pin flag dropped without a read");

	pin_masked_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && status_irq_enable[3:0] == 4'h0 && pin_change_flag == 4'h0
		|=> pin_change_flag == 4'h0)
		else $error("pin flag set while disabled");

	pin_map_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en |=> pin_s1 == $past(pin_in[PIN_BASE +: 4]))
		else $error("pin sampled from wrong position");

	settle_state_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_settled == (clk_state == usi_pkg::USI_CLK_READY))
		else $error("clock settled disagrees with state");

	settle_need_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && !clk_settled && !(pll_locked && div_settled) |=> !clk_settled)
		else $error("clock settled before all parts settled");

	settle_drop_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && !clk_enabled |=> !clk_settled)
		else $error("clock settled kept with clock disabled");

	settle_irq_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && status_irq_enable[5] && !clk_settled && next_clk_settled
		|=> status_summary)
		else $error("clock settled did not raise status summary");

	sts_set_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && sts_hit |=> status_summary)
		else $error("status summary missed an enabled flag");

	sts_block_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && !status_summary && !sts_hit |=> !status_summary)
		else $error("status summary rose with no enabled flag");

	spc_set_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && spc_hit |=> special_summary)
		else $error("special summary missed an enabled event");
endmodule

// ==== test/usi_host_model.sv ====
// Host-side register access model for the secondary interrupt sources
`timescale 1ns/1ps
// ****
// Host access tasks
// ****
module usi_host_model (
	input wire logic clk_sys,
	input wire logic [7:0] reg_rdata,
	output usi_pkg::usi_reg_req_t reg_req
);
	initial reg_req = '0;
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys) #1;
		reg_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(posedge clk_sys) #1;
		reg_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys) #1;
		reg_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		@(posedge clk_sys) #1;
		reg_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hFF};
		d = reg_rdata;
	endtask
endmodule

// ==== test/testbench.sv ====
// Self-checking bench for the secondary interrupt sources
`timescale 1ns/1ps
// ****
// Bench
// ****
module testbench;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic main_status_rd = 1'b0;
	usi_pkg::usi_spc_evt_t spc_evt = '0;
	logic multidrop_on = 1'b1;
	logic special_detect_on = 1'b1;
	logic clk_enabled = 1'b0;
	logic clk_from_xtal = 1'b0;
	logic pll_locked = 1'b1;
	logic div_settled = 1'b1;
	logic [15:0] pin_in = 16'h0000;
	usi_pkg::usi_reg_req_t reg_req;
	logic [7:0] reg_rdata;
	logic special_summary;
	logic status_summary;
	logic [7:0] rd;
	int fail_count = 0;
	int num_checks = 0;
	int cycles = 0;
	always #5 clk_sys = ~clk_sys;
	usi_host_model u_usi_host_model (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_req(reg_req));
	usi_irq_sources #(.UART_INDEX(1), .NUM_PINS(16)) u_usi_irq_sources (
		.clk_sys(clk_sys), .resetn(resetn), .clk_en(1'b1), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .main_status_rd(main_status_rd), .spc_evt(spc_evt),
		.multidrop_on(multidrop_on), .special_detect_on(special_detect_on),
		.clk_enabled(clk_enabled), .clk_from_xtal(clk_from_xtal), .pll_locked(pll_locked),
		.div_settled(div_settled), .pin_in(pin_in), .special_summary(special_summary),
		.status_summary(status_summary));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		u_usi_host_model.rd_reg(a, rd);
		check(rd, exp);
	endtask
	task automatic main_read();
		main_status_rd = 1'b1;
		tick(1);
		main_status_rd = 1'b0;
		tick(1);
	endtask
	task automatic pulse(input logic [5:0] e);
		spc_evt = usi_pkg::usi_spc_evt_t'(e);
		tick(1);
		spc_evt = '0;
		tick(1);
	endtask
	task automatic test_regs();
		for (int a = 5; a <= 9; a++) rdchk(8'(a), 8'h00);
		u_usi_host_model.wr_reg(8'h05, 8'hFF);
		rdchk(8'h05, 8'h3F);
		u_usi_host_model.wr_reg(8'h07, 8'hFF);
		rdchk(8'h07, 8'h2F);
		u_usi_host_model.wr_reg(8'h06, 8'hFF);
		rdchk(8'h06, 8'h00);
	endtask
	task automatic test_special();
		for (int b = 0; b < 6; b++) begin
			pulse(6'h01 << b);
			check({7'h00, special_summary}, 8'h01);
			rdchk(8'h06, 8'h01 << b);
			main_read();
			check({7'h00, special_summary}, 8'h00);
		end
		fork
			u_usi_host_model.rd_reg(8'h06, rd);
			begin
				@(posedge clk_sys) #1;
				pulse(6'h02);
			end
		join
		check(rd, 8'h00);
		rdchk(8'h06, 8'h02);
		main_read();
		u_usi_host_model.wr_reg(8'h05, 8'h00);
		pulse(6'h10);
		check({7'h00, special_summary}, 8'h00);
		rdchk(8'h06, 8'h10);
		rdchk(8'h06, 8'h00);
		multidrop_on = 1'b0;
		special_detect_on = 1'b0;
		pulse(6'h24);
		rdchk(8'h06, 8'h00);
	endtask
	task automatic test_status();
		u_usi_host_model.wr_reg(8'h07, 8'h0F);
		main_read();
		for (int n = 0; n < 4; n++) begin
			pin_in[4 + n] = 1'b1;
			tick(6);
			rdchk(8'h08, 8'h01 << n);
		end
		check({7'h00, status_summary}, 8'h01);
		rdchk(8'h08, 8'h00);
		pin_in[0] = 1'b1;
		u_usi_host_model.wr_reg(8'h07, 8'h20);
		pin_in[5] = 1'b0;
		tick(6);
		rdchk(8'h08, 8'h00);
		main_read();
		clk_enabled = 1'b1;
		tick(5);
		rdchk(8'h08, 8'h00);
		check({7'h00, status_summary}, 8'h00);
		clk_from_xtal = 1'b1;
		tick(5);
		rdchk(8'h08, 8'h20);
		check({7'h00, status_summary}, 8'h01);
		rdchk(8'h08, 8'h20);
		clk_enabled = 1'b0;
		tick(3);
		rdchk(8'h08, 8'h00);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			give_verdict();
		end
	end
	initial begin
		tick(3);
		resetn = 1'b1;
		test_regs();
		test_special();
		test_status();
		give_verdict();
	end
endmodule
